//--- bmc_top.sv
// Upper half of the basic mode control register with its management slave.
// Assumes MDC, MDIO and strap pins are synchronous to CLOCK; MDIO is split
// into input, output and enable, the wire is resolved outside.
`timescale 1ns/10ps
`default_nettype none
module bmc_top #(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int DATA_W = 4
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic MDC,
	input wire logic MDIO_IN,
	output logic MDIO_OUT,
	output logic MDIO_OE,
	input wire logic INTERRUPT_POWERDOWN_PIN_N,
	input wire logic STRAP_SPEED_100,
	input wire logic STRAP_AUTONEG,
	input wire logic STRAP_DUPLEX,
	input wire logic AN_SPEED_100,
	input wire logic AN_FULL_DUPLEX,
	output logic SPEED_100,
	output logic FULL_DUPLEX,
	output logic AUTONEG_EN,
	output logic POWER_DOWN,
	output logic COLLISION_TEST,
	output logic PHY_CORE_RST,
	input wire logic [DATA_W-1:0] MII_TXD,
	input wire logic MII_TX_EN,
	output logic [DATA_W-1:0] MII_RXD,
	output logic MII_RX_DV,
	output logic MII_RX_OE,
	input wire logic [DATA_W-1:0] LINE_RXD,
	input wire logic LINE_RX_DV,
	output logic [DATA_W-1:0] LINE_TXD,
	output logic LINE_TX_EN
);

	bmc_pkg::bmc_smi_state_t st_r;
	logic mdc_q_r;
	logic mdc_rise;
	logic [5:0] pre_r;
	logic [3:0] cnt_r;
	logic [15:0] sh_r;
	logic op_rd_r;
	logic op_wr_r;
	logic hit_r;
	logic wr_go;
	logic [15:0] wr_word;
	logic [15:0] rd_word;
	logic loop_r;
	logic speed_r;
	logic an_r;
	logic pd_r;
	logic iso_r;
	logic dup_r;
	logic coltest_r;
	logic busy_r;
	logic [7:0] rcnt_r;
	logic strap_ld_r;
	logic pin_req;
	bmc_ctl_if ctl ();

	// The pin is active low; a low level is a power-down request.
	assign pin_req = !INTERRUPT_POWERDOWN_PIN_N;

	// MDC is treated as a synchronous level, so one delayed copy finds its rise.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mdc_q_r <= 1'b0;
		end else begin
			mdc_q_r <= MDC;
		end
	end

	assign mdc_rise = MDC && !mdc_q_r;

	// management stays alive
	// Frame decoder; one shift register serves both read-out and write-in.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_r <= bmc_pkg::SMI_IDLE;
			pre_r <= '0;
			cnt_r <= '0;
			sh_r <= '0;
			op_rd_r <= 1'b0;
			op_wr_r <= 1'b0;
			hit_r <= 1'b0;
			MDIO_OUT <= 1'b0;
			MDIO_OE <= 1'b0;
		end else if (mdc_rise) begin
			case (st_r)
				bmc_pkg::SMI_IDLE: begin
					if (MDIO_IN) begin
						if (pre_r != bmc_pkg::PREAMBLE_LEN) begin
							pre_r <= pre_r + 6'h01;
						end
					end else begin
						if (pre_r == bmc_pkg::PREAMBLE_LEN) begin
							st_r <= bmc_pkg::SMI_START;
						end
						pre_r <= '0;
					end
				end
				bmc_pkg::SMI_START: begin
					st_r <= MDIO_IN ? bmc_pkg::SMI_OPCODE : bmc_pkg::SMI_IDLE;
					cnt_r <= '0;
				end
				bmc_pkg::SMI_OPCODE: begin
					sh_r <= {sh_r[14:0], MDIO_IN};
					if (cnt_r == 4'h1) begin
						op_rd_r <= ({sh_r[0], MDIO_IN} == bmc_pkg::OP_READ);
						op_wr_r <= ({sh_r[0], MDIO_IN} == bmc_pkg::OP_WRITE);
						st_r <= bmc_pkg::SMI_ADDR;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				bmc_pkg::SMI_ADDR: begin
					sh_r <= {sh_r[14:0], MDIO_IN};
					if (cnt_r == bmc_pkg::LAST_ADDR_BIT) begin
						hit_r <= ({sh_r[8:0], MDIO_IN} == {PHY_ADDR, bmc_pkg::REG_ADDR})
							&& (op_rd_r || op_wr_r);
						st_r <= bmc_pkg::SMI_TURN;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				bmc_pkg::SMI_TURN: begin
					if (cnt_r == 4'h0) begin
						// Drive the second turnaround bit low on a read that hits us.
						MDIO_OE <= hit_r && op_rd_r;
						MDIO_OUT <= 1'b0;
						cnt_r <= 4'h1;
					end else begin
						MDIO_OUT <= hit_r && op_rd_r && rd_word[15];
						sh_r <= {rd_word[14:0], 1'b0};
						st_r <= bmc_pkg::SMI_DATA;
						cnt_r <= '0;
					end
				end
				bmc_pkg::SMI_DATA: begin
					sh_r <= {sh_r[14:0], MDIO_IN};
					if (cnt_r == bmc_pkg::LAST_DATA_BIT) begin
						MDIO_OE <= 1'b0;
						MDIO_OUT <= 1'b0;
						st_r <= bmc_pkg::SMI_IDLE;
						cnt_r <= '0;
					end else begin
						MDIO_OUT <= MDIO_OE && sh_r[15];
						cnt_r <= cnt_r + 4'h1;
					end
				end
				default: begin
					st_r <= bmc_pkg::SMI_IDLE;
					MDIO_OE <= 1'b0;
				end
			endcase
		end
	end

	// A write commits on the edge that samples its last data bit.
	always_comb begin
		wr_word = {sh_r[14:0], MDIO_IN};
		wr_go = mdc_rise && (st_r == bmc_pkg::SMI_DATA) && (cnt_r == bmc_pkg::LAST_DATA_BIT)
			&& op_wr_r && hit_r;
	end

	// reset bit readback
	// Bit 9 and bits 6 to 0 are not held here and read as zero.
	always_comb begin
		rd_word = '0;
		rd_word[bmc_pkg::BIT_RESET] = busy_r;
		rd_word[bmc_pkg::BIT_LOOPBACK] = loop_r;
		rd_word[bmc_pkg::BIT_SPEED] = speed_r;
		rd_word[bmc_pkg::BIT_AUTONEG] = an_r;
		rd_word[bmc_pkg::BIT_POWERDOWN] = pd_r;
		rd_word[bmc_pkg::BIT_ISOLATE] = iso_r;
		rd_word[bmc_pkg::BIT_DUPLEX] = dup_r;
		rd_word[bmc_pkg::BIT_COLTEST] = coltest_r;
	end

	// software reset sequence
	// Writes are refused while the reset runs, so the strap reload is not undone.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			busy_r <= 1'b0;
			rcnt_r <= '0;
		end else if (busy_r) begin
			if (rcnt_r != 8'h00) begin
				rcnt_r <= rcnt_r - 8'h01;
			end else begin
				busy_r <= 1'b0;
			end
		end else if (wr_go && wr_word[bmc_pkg::BIT_RESET]) begin
			busy_r <= 1'b1;
			rcnt_r <= bmc_pkg::SOFT_RST_LOAD;
		end
	end

	// strap capture at release
	// Straps are caught one edge after reset release, never under the reset itself.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strap_ld_r <= 1'b1;
		end else begin
			strap_ld_r <= 1'b0;
		end
	end

	// strap relatch
	// Strap-defaulted fields reload at power-up and when a software reset ends.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			speed_r <= bmc_pkg::RST_SPEED;
			an_r <= bmc_pkg::RST_AUTONEG;
			dup_r <= bmc_pkg::RST_DUPLEX;
		end else if (strap_ld_r || (busy_r && rcnt_r == 8'h00)) begin
			speed_r <= STRAP_SPEED_100;
			an_r <= STRAP_AUTONEG;
			dup_r <= STRAP_DUPLEX;
		end else if (wr_go && !busy_r && !wr_word[bmc_pkg::BIT_RESET]) begin
			speed_r <= wr_word[bmc_pkg::BIT_SPEED];
			an_r <= wr_word[bmc_pkg::BIT_AUTONEG];
			dup_r <= wr_word[bmc_pkg::BIT_DUPLEX];
		end
	end

	// plain control bits
	// The software reset returns these to their reset values.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			loop_r <= bmc_pkg::RST_LOOPBACK;
			iso_r <= bmc_pkg::RST_ISOLATE;
			coltest_r <= bmc_pkg::RST_COLTEST;
		end else if (busy_r || (wr_go && wr_word[bmc_pkg::BIT_RESET])) begin
			loop_r <= bmc_pkg::RST_LOOPBACK;
			iso_r <= bmc_pkg::RST_ISOLATE;
			coltest_r <= bmc_pkg::RST_COLTEST;
		end else if (wr_go) begin
			loop_r <= wr_word[bmc_pkg::BIT_LOOPBACK];
			iso_r <= wr_word[bmc_pkg::BIT_ISOLATE];
			coltest_r <= wr_word[bmc_pkg::BIT_COLTEST];
		end
	end

	// pin sets bit
	// The pin wins over a write of zero in the same cycle, so no request is lost.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pd_r <= bmc_pkg::RST_POWERDOWN;
		end else if (busy_r || (wr_go && wr_word[bmc_pkg::BIT_RESET])) begin
			pd_r <= pin_req;
		end else if (wr_go) begin
			pd_r <= wr_word[bmc_pkg::BIT_POWERDOWN] || pin_req;
		end else begin
			pd_r <= pd_r || pin_req;
		end
	end

	// manual speed and duplex
	// Negotiated results are used as given; the manual bits only count when off.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SPEED_100 <= bmc_pkg::RST_SPEED;
			FULL_DUPLEX <= bmc_pkg::RST_DUPLEX;
			AUTONEG_EN <= bmc_pkg::RST_AUTONEG;
		end else begin
			SPEED_100 <= an_r ? AN_SPEED_100 : speed_r;
			FULL_DUPLEX <= an_r ? AN_FULL_DUPLEX : dup_r;
			AUTONEG_EN <= an_r;
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			POWER_DOWN <= 1'b0;
			PHY_CORE_RST <= 1'b0;
			COLLISION_TEST <= 1'b0;
		end else begin
			POWER_DOWN <= pd_r || pin_req;
			PHY_CORE_RST <= busy_r;
			COLLISION_TEST <= coltest_r && !pd_r && !busy_r;
		end
	end

	// minimal logic in power-down
	// The data path and the collision test output are gated; the register bank and frame decoder keep running.
	assign ctl.loopback = loop_r;
	assign ctl.isolate = iso_r;
	assign ctl.powerdown = POWER_DOWN;
	assign ctl.core_rst = PHY_CORE_RST;

	bmc_datapath #(
		.DATA_W(DATA_W)
	) u_datapath (
		.clk(CLOCK),
		.rst(SYS_RST),
		.ctl(ctl),
		.mii_txd(MII_TXD),
		.mii_tx_en(MII_TX_EN),
		.line_rxd(LINE_RXD),
		.line_rx_dv(LINE_RX_DV),
		.mii_rxd(MII_RXD),
		.mii_rx_dv(MII_RX_DV),
		.mii_rx_oe(MII_RX_OE),
		.line_txd(LINE_TXD),
		.line_tx_en(LINE_TX_EN)
	);

	reset_self_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) $rose(busy_r) |-> ##249 busy_r ##1 !busy_r) else $error("software reset length wrong");

	reset_reads_one_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) (busy_r == rd_word[15]) && (busy_r == PHY_CORE_RST || $changed(busy_r))) else $error("reset bit readback wrong");

	strap_relatch_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) $fell(busy_r) |-> (speed_r == $past(STRAP_SPEED_100) && an_r == $past(STRAP_AUTONEG) && dup_r == $past(STRAP_DUPLEX))) else $error("straps not relatched");

	manual_speed_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) !an_r |=> (SPEED_100 == $past(speed_r) && FULL_DUPLEX == $past(dup_r))) else $error("manual speed or duplex not applied");

	autoneg_ignore_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) an_r |=> (SPEED_100 == $past(AN_SPEED_100) && FULL_DUPLEX == $past(AN_FULL_DUPLEX))) else $error("manual bits used under autoneg");

	powerdown_or_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) (pd_r || pin_req) |=> POWER_DOWN) else $error("power down request lost");

	pin_sets_bit_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) pin_req |=> pd_r) else $error("pin did not set power down bit");

	reset_clears_bits_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) $rose(busy_r) |=> (!loop_r && !iso_r && pd_r == $past(pin_req))) else $error("control bits not cleared by reset");

	write_applies_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) (wr_go && !busy_r && !wr_word[15]) |=> (loop_r == $past(wr_word[14]) && iso_r == $past(wr_word[10]))) else $error("register write not applied");

endmodule
`default_nettype wire

//--- bmc_pkg.sv
// Constants shared by the upper basic mode control register, its management model and its bench.
// Assumes a single 250 MHz core clock and management pins sampled on it.
package bmc_pkg;

	// Management frame field values and register selection.
	localparam logic [4:0] REG_ADDR = 5'h00;
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [3:0] LAST_DATA_BIT = 4'hf;
	localparam logic [3:0] LAST_ADDR_BIT = 4'h9;

	// Bit positions inside the 16-bit control word.
	localparam int BIT_RESET = 15;
	localparam int BIT_LOOPBACK = 14;
	localparam int BIT_SPEED = 13;
	localparam int BIT_AUTONEG = 12;
	localparam int BIT_POWERDOWN = 11;
	localparam int BIT_ISOLATE = 10;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_COLTEST = 7;

	// Values after hardware reset, before the straps are taken in.
	localparam logic RST_LOOPBACK = 1'b0;
	localparam logic RST_SPEED = 1'b1;
	localparam logic RST_AUTONEG = 1'b1;
	localparam logic RST_POWERDOWN = 1'b0;
	localparam logic RST_ISOLATE = 1'b0;
	localparam logic RST_DUPLEX = 1'b1;
	localparam logic RST_COLTEST = 1'b0;

	// Duration of the software-initiated reset of the physical layer.
	localparam int CLK_MHZ = 250;
	localparam int SOFT_RST_TIME_NS = 1000;
	localparam int SOFT_RST_CYCLES = (SOFT_RST_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SOFT_RST_LOAD = 8'(SOFT_RST_CYCLES - 1);

	// Management frame states, Gray coded along the frame.
	typedef enum logic [2:0] {
		SMI_IDLE = 3'h0,
		SMI_START = 3'h1,
		SMI_OPCODE = 3'h3,
		SMI_ADDR = 3'h2,
		SMI_TURN = 3'h6,
		SMI_DATA = 3'h7
	} bmc_smi_state_t;

endpackage

//--- bmc_ctl_if.sv
// Control levels passed from the register bank to the MII data path.
// Assumes both ends run on the same clock; all levels come from flip-flops.
`timescale 1ns/10ps
`default_nettype none
interface bmc_ctl_if;
	logic loopback;
	logic isolate;
	logic powerdown;
	logic core_rst;
	modport src (output loopback, output isolate, output powerdown, output core_rst);
	modport dp (input loopback, input isolate, input powerdown, input core_rst);
endinterface
`default_nettype wire

//--- bmc_datapath.sv
// MII data path: loopback, isolation and power-down gating of the nibble streams.
// Assumes MII and line-side inputs are synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module bmc_datapath #(
	parameter int DATA_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	bmc_ctl_if.dp ctl,
	input wire logic [DATA_W-1:0] mii_txd,
	input wire logic mii_tx_en,
	input wire logic [DATA_W-1:0] line_rxd,
	input wire logic line_rx_dv,
	output logic [DATA_W-1:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_rx_oe,
	output logic [DATA_W-1:0] line_txd,
	output logic line_tx_en
);

	logic active;

	// Nothing moves while the core is in reset or powered down.
	assign active = !ctl.core_rst && !ctl.powerdown;

	// isolation enable
	// The receive outputs float while isolated so another port can share the MII.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mii_rx_oe <= 1'b0;
		end else begin
			mii_rx_oe <= !ctl.isolate;
		end
	end

	// loopback routing
	// Loopback keeps the line transmitter quiet so no frame leaks to the cable.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mii_rxd <= '0;
			mii_rx_dv <= 1'b0;
			line_txd <= '0;
			line_tx_en <= 1'b0;
		end else if (!active || ctl.isolate) begin
			mii_rxd <= '0;
			mii_rx_dv <= 1'b0;
			line_txd <= '0;
			line_tx_en <= 1'b0;
		end else if (ctl.loopback) begin
			mii_rxd <= mii_txd;
			mii_rx_dv <= mii_tx_en;
			line_txd <= '0;
			line_tx_en <= 1'b0;
		end else begin
			mii_rxd <= line_rxd;
			mii_rx_dv <= line_rx_dv;
			line_txd <= mii_txd;
			line_tx_en <= mii_tx_en;
		end
	end

	loopback_path_a: assert property (@(posedge clk) disable iff (rst) (ctl.loopback && !ctl.isolate && active) |=> (mii_rxd == $past(mii_txd) && !line_tx_en)) else $error("loopback data not returned");

	isolate_hiz_a: assert property (@(posedge clk) disable iff (rst) ctl.isolate |=> (!mii_rx_oe && !line_tx_en && !mii_rx_dv)) else $error("isolated port still drives");

	powerdown_quiet_a: assert property (@(posedge clk) disable iff (rst) ctl.powerdown |=> (!line_tx_en && !mii_rx_dv)) else $error("data moves in power down");

endmodule
`default_nettype wire

//--- bmc_mgr_model.sv
// Station manager and MAC transmit model facing the upper control register.
// Assumes the bench resolves the shared MDIO wire with its pull-up.
`timescale 1ns/10ps
`default_nettype none
module bmc_mgr_model (
	input wire logic clk,
	input wire logic mdio,
	output logic mdc,
	output logic mdo,
	output logic mdo_en,
	output logic [3:0] mii_txd,
	output logic mii_tx_en
);
	// Idle state: management clock parked low, data released, MAC quiet.
	initial begin
		mdc = 1'b0;
		mdo = 1'b0;
		mdo_en = 1'b0;
		mii_txd = 4'h0;
		mii_tx_en = 1'b0;
	end

	// One bit: a core cycle low, then the rise; sampling just before the rise
	// sees what the device launched after the previous rise.
	task automatic mdio_bit(input logic drv, input logic val, output logic smp);
		@(negedge clk);
		mdc = 1'b0;
		mdo_en = drv;
		mdo = val;
		@(negedge clk);
		smp = mdio;
		mdc = 1'b1;
	endtask

	// Whole frame with full preamble; on a read the turnaround and data are released.
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [13:0] hdr;
		logic s;
		logic wr;
		hdr = {2'b01, op, phy, bmc_pkg::REG_ADDR};
		wr = (op == bmc_pkg::OP_WRITE);
		for (int i = 0; i < 32; i++) begin
			mdio_bit(1'b1, 1'b1, s);
		end
		for (int i = 13; i >= 0; i--) begin
			mdio_bit(1'b1, hdr[i], s);
		end
		for (int i = 1; i >= 0; i--) begin
			mdio_bit(wr, i[0], s);
		end
		for (int i = 15; i >= 0; i--) begin
			mdio_bit(wr, wd[i], s);
			rd[i] = s;
		end
		@(negedge clk);
		mdc = 1'b0;
		mdo_en = 1'b0;
	endtask

	// One transmit nibble, changed off the sampling edge.
	task automatic mii_send(input logic [3:0] d, input logic en);
		@(negedge clk);
		mii_txd = d;
		mii_tx_en = en;
	endtask
endmodule
`default_nettype wire

//--- tb_phy_basic_mode_control_upper.sv
// Self-checking bench for the upper basic mode control register.
// Assumes the management model above and a pulled-up MDIO wire.
`timescale 1ns/10ps
`default_nettype none
module tb_phy_basic_mode_control_upper;
	logic clock, sys_rst, mdc, mdo, mdo_en, mdio, pin_n;
	logic st_spd, st_an, st_dup, an_spd, an_dup, mdio_out, mdio_oe;
	logic speed_100, full_duplex, autoneg_en, power_down, col_test, core_rst;
	logic [3:0] mii_txd, mii_rxd, line_rxd, line_txd;
	logic mii_tx_en, mii_rx_dv, mii_rx_oe, line_rx_dv, line_tx_en;
	int num_errors = 0;
	int checked = 0;

	// Released MDIO floats to the pull-up level.
	assign mdio = mdio_oe ? mdio_out : (mdo_en ? mdo : 1'b1);

	bmc_top #(.PHY_ADDR(5'h01), .DATA_W(4)) bmc_top_i (.CLOCK(clock), .SYS_RST(sys_rst),
		.MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
		.INTERRUPT_POWERDOWN_PIN_N(pin_n), .STRAP_SPEED_100(st_spd), .STRAP_AUTONEG(st_an),
		.STRAP_DUPLEX(st_dup), .AN_SPEED_100(an_spd), .AN_FULL_DUPLEX(an_dup),
		.SPEED_100(speed_100), .FULL_DUPLEX(full_duplex), .AUTONEG_EN(autoneg_en),
		.POWER_DOWN(power_down), .COLLISION_TEST(col_test), .PHY_CORE_RST(core_rst),
		.MII_TXD(mii_txd), .MII_TX_EN(mii_tx_en), .MII_RXD(mii_rxd), .MII_RX_DV(mii_rx_dv),
		.MII_RX_OE(mii_rx_oe), .LINE_RXD(line_rxd), .LINE_RX_DV(line_rx_dv),
		.LINE_TXD(line_txd), .LINE_TX_EN(line_tx_en));

	bmc_mgr_model mgr_i (.clk(clock), .mdio(mdio), .mdc(mdc), .mdo(mdo), .mdo_en(mdo_en),
		.mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

	// Core clock at 250 MHz.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Prints the counts and the verdict, then ends the run.
	task finish_test;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compares one value against its expectation and counts the result.
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Register access; the wait after a write lets the outputs settle.
	task automatic wr(input logic [15:0] d);
		logic [15:0] v;
		mgr_i.frame(bmc_pkg::OP_WRITE, 5'h01, d, v);
		repeat (3) @(negedge clock);
	endtask

	task automatic rd(output logic [15:0] v);
		mgr_i.frame(bmc_pkg::OP_READ, 5'h01, 16'h0000, v);
	endtask

	// Values after hardware reset, with speed strapped high and the rest low.
	task automatic t_reset_values;
		logic [15:0] v;
		rd(v);
		check(v, 16'h2000);
		check({11'h0, speed_100, full_duplex, autoneg_en, power_down, mii_rx_oe}, 16'h0011);
	endtask

	// One manual or negotiated speed and duplex setting.
	task automatic sd_case(input logic [15:0] wd, input logic [1:0] exp);
		logic [15:0] v;
		wr(wd);
		rd(v);
		check(v, wd);
		check({14'h0, speed_100, full_duplex}, {14'h0, exp});
	endtask

	// Manual bits rule only while negotiation is off.
	task automatic t_speed_duplex;
		sd_case(16'h0100, 2'b01);
		sd_case(16'h2000, 2'b10);
		sd_case(16'h1000, 2'b11);
		an_spd = 1'b0;
		an_dup = 1'b0;
		sd_case(16'h3100, 2'b00);
	endtask

	// Loopback returns transmit nibbles and keeps the line quiet.
	task automatic t_loopback;
		logic [3:0] d;
		wr(16'h4000);
		for (int i = 1; i < 4; i++) begin
			d = 4'(i * 5);
			mgr_i.mii_send(d, 1'b1);
			@(negedge clock);
			check({10'h0, mii_rxd, mii_rx_dv, line_tx_en}, {10'h0, d, 2'b10});
		end
		wr(16'h0000);
		mgr_i.mii_send(4'h9, 1'b1);
		@(negedge clock);
		check({7'h0, line_txd, line_tx_en, mii_rxd}, {7'h0, 4'h9, 1'b1, 4'h6});
	endtask

	// Isolation floats the receive side while management still answers.
	task automatic t_isolate;
		logic [15:0] v;
		wr(16'h0400);
		rd(v);
		check(v, 16'h0400);
		mgr_i.mii_send(4'h7, 1'b1);
		@(negedge clock);
		check({10'h0, mii_rx_oe, mii_rxd, line_tx_en}, 16'h0000);
		wr(16'h0000);
		check({15'h0, mii_rx_oe}, 16'h0001);
	endtask

	// Power-down from the bit and from the pin; the pin leaves the bit set.
	task automatic t_power_down;
		logic [15:0] v;
		wr(16'h0080);
		check({15'h0, col_test}, 16'h0001);
		wr(16'h0880);
		rd(v);
		check(v, 16'h0880);
		check({15'h0, col_test}, 16'h0000);
		check({14'h0, power_down, line_tx_en}, 16'h0002);
		wr(16'h0000);
		pin_n = 1'b0;
		repeat (3) @(negedge clock);
		check({15'h0, power_down}, 16'h0001);
		pin_n = 1'b1;
		rd(v);
		check(v, 16'h0800);
		wr(16'h0000);
		check({15'h0, power_down}, 16'h0000);
	endtask

	// Software reset: busy bit, self-clear after 250 cycles, straps taken again.
	task automatic t_soft_reset;
		logic [15:0] v;
		time t0;
		int n;
		st_spd = 1'b0;
		st_an = 1'b1;
		st_dup = 1'b1;
		an_dup = 1'b1;
		wr(16'h8000);
		t0 = $time;
		check({15'h0, core_rst}, 16'h0001);
		rd(v);
		check({15'h0, v[15]}, 16'h0001);
		n = 0;
		while (core_rst === 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		n = int'(($time - t0) / 4);
		check({15'h0, n >= 244 && n <= 250}, 16'h0001);
		rd(v);
		check(v, 16'h1100);
		check({14'h0, speed_100, full_duplex}, 16'h0001);
	endtask

	// Main sequence: hold reset for ten cycles, then run each scenario.
	initial begin
		sys_rst = 1'b1;
		pin_n = 1'b1;
		st_spd = 1'b1;
		st_an = 1'b0;
		st_dup = 1'b0;
		an_spd = 1'b1;
		an_dup = 1'b1;
		line_rxd = 4'h6;
		line_rx_dv = 1'b1;
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		repeat (3) @(negedge clock);
		t_reset_values();
		t_speed_duplex();
		t_loopback();
		t_isolate();
		t_power_down();
		t_soft_reset();
		finish_test();
	end

	// Watchdog well beyond the roughly 3200 cycles the scenarios need.
	initial begin
		repeat (20000) @(negedge clock);
		num_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
